//--- hdl/ctsmp_top.sv
`timescale 1ns/1ps
// Contract
// - each channel keeps an on-state current used for burnout and display.
// - each channel keeps a separate off-state current, never displayed.
// - burnout mode takes on-value with watched output ON, off-value when OFF.
// - measurement mode updates on-value every time, off-value stays 0.0 A.
// - each channel has its own operation type, 0 burnout detection, default 0.
// - burnout mode waits 20 to 300 ms, default 30 ms, after each change.
// - each measurement runs 100 ms and completes only after that interval.
// - turns take 1 to 40 in hundreds, 0 means 8, default 8.
// - loops take 1 to 6, 0 means one pass, default 1.
// - display range is zero to turns/(16*loops)*1.4 A.
// - valid measurement range is turns/(2000*loops) to turns/(16*loops) A.
// - a current above the display upper limit raises the input failure alarm, unless the raw peak saturates.
// - range and current arithmetic errs by less than 0.1 A.
// - before firmware 2.04 use 800 turns, one loop and no alarm.
module ctsmp_top
  import ctsmp_pkg::*;
#(
  parameter int MEAS_CYCLES = MEAS_CYC,   // 100 ms measurement window
  parameter int CYC_MS      = CYC_PER_MS  // clock cycles per millisecond
) (
  input  wire logic                      clk_sys,                  // clock
  input  wire logic                      rst_b,                    // reset
  input  wire logic [NOUT-1:0]           out_state,                // outputs
  input  wire logic [NCH-1:0]            raw_valid,                // strobe
  input  wire logic [NCH-1:0][RAW_W-1:0] raw_current,              // uA
  input  wire logic                      chan1_operation_type,     // type
  input  wire logic                      chan2_operation_type,     // type
  input  wire logic [NCH-1:0][2:0]       monitor_sel,              // watch
  input  wire logic [NCH-1:0][8:0]       wait_ms,                  // delay
  input  wire logic [NCH-1:0][5:0]       turns_set,                // turns
  input  wire logic [NCH-1:0][2:0]       loops_set,                // loops
  input  wire logic [15:0]               firmware_version_item,    // ver
  output logic      [NCH-1:0][CUR_W-1:0] on_current,               // 0.01A
  output logic      [NCH-1:0][CUR_W-1:0] off_current,              // 0.01A
  output logic      [NCH-1:0]            on_update,                // pulse
  output logic      [NCH-1:0]            input_failure_alarm,      // level
  output logic      [NCH-1:0][CUR_W-1:0] disp_upper,               // 0.01A
  output logic      [NCH-1:0][CUR_W-1:0] meas_lower,               // 0.01A
  output logic      [NCH-1:0][CUR_W-1:0] meas_upper                // 0.01A
);
  function automatic logic [TMR_W-1:0] wait_cycles(input logic [8:0] ms);
    logic [8:0] c;
    c = (ms < WAIT_MIN_MS) ? WAIT_MIN_MS :
        (ms > WAIT_MAX_MS) ? WAIT_MAX_MS : ms;
    return TMR_W'(c * CYC_MS - 1);
  endfunction

  ctsmp_state_t               state      [NCH];
  ctsmp_state_t               next_state [NCH];
  logic [TMR_W-1:0]           tmr        [NCH];
  logic [TMR_W-1:0]           next_tmr   [NCH];
  logic [RAW_W-1:0]           peak       [NCH];
  logic [RAW_W-1:0]           next_peak  [NCH];
  logic [NCH-1:0]             mon_prev;
  logic [NCH-1:0]             next_mon_prev;
  logic [NCH-1:0]             phase;
  logic [NCH-1:0]             next_phase;
  logic [NCH-1:0][CUR_W-1:0]  next_on;
  logic [NCH-1:0][CUR_W-1:0]  next_off;
  logic [NCH-1:0]             next_upd;
  logic [NCH-1:0]             next_alarm;
  logic [NCH-1:0]             optype;
  logic [NCH-1:0]             mon;
  logic [NCH-1:0]             edge_seen;
  logic [NCH-1:0]             done;
  logic                       legacy;
  logic [NCH-1:0][5:0]        eff_turns;
  logic [NCH-1:0][2:0]        eff_loops;
  logic [NCH-1:0][CUR_W-1:0]  disp_hi;
  logic [NCH-1:0][CUR_W-1:0]  lo_c;
  logic [NCH-1:0][CUR_W-1:0]  hi_c;
  logic [NCH-1:0][CUR_W-1:0]  scaled;

  assign legacy = firmware_version_item < FW_MIN_VER;
  assign optype = {chan2_operation_type, chan1_operation_type};

  for (genvar g = 0; g < NCH; g++) begin : g_rng
    ctsmp_range u_range (
      .turns_set (turns_set[g]),
      .loops_set (loops_set[g]),
      .legacy    (legacy),
      .raw_peak  (peak[g]),
      .eff_turns (eff_turns[g]),
      .eff_loops (eff_loops[g]),
      .disp_hi   (disp_hi[g]),
      .meas_lo   (lo_c[g]),
      .meas_hi   (hi_c[g]),
      .scaled    (scaled[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // out-of-range selector watches nothing new
      mon[i] = (monitor_sel[i] > SEL_MAX) ? 1'b0
               : out_state[monitor_sel[i]];
      edge_seen[i]     = mon[i] != mon_prev[i];
      done[i]          = state[i] == CTSMP_MEAS && tmr[i] == '0;
      next_state[i]    = state[i];
      next_tmr[i]      = (tmr[i] == '0) ? tmr[i] : tmr[i] - 1'b1;
      next_peak[i]     = peak[i];
      next_phase[i]    = phase[i];
      next_mon_prev[i] = mon[i];
      next_on[i]       = on_current[i];
      next_off[i]      = off_current[i];
      next_upd[i]      = 1'b0;
      next_alarm[i]    = input_failure_alarm[i];
      if (state[i] == CTSMP_MEAS && raw_valid[i] &&
          raw_current[i] > peak[i]) begin
        next_peak[i] = raw_current[i];
      end
      if (legacy) begin
        next_alarm[i] = 1'b0;
      end else if (done[i] &&
                   !(optype[i] == OP_BURNOUT && edge_seen[i])) begin
        // huge overcurrent saturates the front end and goes unreported
        next_alarm[i] = peak[i] < RAW_SAT &&
                        scaled[i] > disp_hi[i];
      end
      if (optype[i] == OP_MEASURE) begin
        next_off[i] = '0;
        if (state[i] != CTSMP_MEAS || done[i]) begin
          next_state[i] = CTSMP_MEAS;
          next_tmr[i]   = TMR_W'(MEAS_CYCLES - 1);
          next_peak[i]  = '0;
        end
        if (done[i]) begin
          next_on[i]  = scaled[i];
          next_upd[i] = 1'b1;
        end
      end else if (edge_seen[i]) begin
        next_state[i] = CTSMP_WAIT;
        next_tmr[i]   = wait_cycles(wait_ms[i]);
        next_peak[i]  = '0;
      end else begin
        unique case (state[i])
          CTSMP_IDLE: begin
          end
          CTSMP_WAIT: begin
            if (tmr[i] == '0) begin
              next_state[i] = CTSMP_MEAS;
              next_tmr[i]   = TMR_W'(MEAS_CYCLES - 1);
              next_phase[i] = mon[i];
            end
          end
          CTSMP_MEAS: begin
            if (done[i]) begin
              next_state[i] = CTSMP_IDLE;
              if (phase[i]) begin
                next_on[i]  = scaled[i];
                next_upd[i] = 1'b1;
              end else begin
                next_off[i] = scaled[i];
              end
            end
          end
          default: next_state[i] = CTSMP_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        state[i] <= CTSMP_IDLE;
        tmr[i]   <= '0;
        peak[i]  <= '0;
      end
      mon_prev            <= '0;
      phase               <= '0;
      on_current          <= '0;
      off_current         <= '0;
      on_update           <= '0;
      input_failure_alarm <= '0;
      disp_upper          <= '0;
      meas_lower          <= '0;
      meas_upper          <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        state[i] <= next_state[i];
        tmr[i]   <= next_tmr[i];
        peak[i]  <= next_peak[i];
      end
      mon_prev            <= next_mon_prev;
      phase               <= next_phase;
      on_current          <= next_on;
      off_current         <= next_off;
      on_update           <= next_upd;
      input_failure_alarm <= next_alarm;
      disp_upper          <= disp_hi;
      meas_lower          <= lo_c;
      meas_upper          <= hi_c;
    end
  end

  // checks for channel 0; channel 1 shares the same logic
  logic [TMR_W-1:0] meas_len;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meas_len <= '0;
    end else begin
      meas_len <= (state[0] == CTSMP_MEAS && !done[0]) ? meas_len + 1'b1
                                                       : '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_wait_after_edge: assert property (
    optype[0] == OP_BURNOUT && edge_seen[0]
    |=> state[0] == CTSMP_WAIT && tmr[0] == wait_cycles($past(wait_ms[0])))
    else $error("wait not started after output change");
  a_meas_length: assert property (
    done[0] && $past(state[0]) == CTSMP_MEAS && $past(tmr[0]) == 1
    |-> meas_len == TMR_W'(MEAS_CYCLES - 1))
    else $error("measurement window length wrong");
  a_abort_restart: assert property (
    optype[0] == OP_BURNOUT && edge_seen[0] && state[0] == CTSMP_MEAS
    |=> state[0] == CTSMP_WAIT && !on_update[0])
    else $error("measurement not aborted on output change");
  a_on_capture: assert property (
    optype[0] == OP_BURNOUT && !edge_seen[0] && done[0] && phase[0]
    |=> on_current[0] == $past(scaled[0]) && on_update[0])
    else $error("on-state value not captured");
  a_off_capture: assert property (
    optype[0] == OP_BURNOUT && !edge_seen[0] && done[0] && !phase[0]
    |=> off_current[0] == $past(scaled[0]) && !on_update[0])
    else $error("off-state value not captured");
  a_measure_mode: assert property (
    optype[0] == OP_MEASURE && done[0]
    |=> off_current[0] == '0 && on_current[0] == $past(scaled[0]))
    else $error("measurement mode values wrong");
  a_alarm_legacy: assert property (
    legacy |=> !input_failure_alarm[0])
    else $error("alarm raised on legacy firmware");
  a_alarm_over: assert property (
    !legacy && done[0] && !(optype[0] == OP_BURNOUT && edge_seen[0]) &&
    peak[0] < RAW_SAT && scaled[0] > disp_hi[0]
    |=> input_failure_alarm[0])
    else $error("over-range current not alarmed");
  a_turns_zero: assert property (
    !legacy && turns_set[0] == 6'h00 |-> eff_turns[0] == TURNS_DEF)
    else $error("zero turns not read as eight");
  a_loops_zero: assert property (
    !legacy && loops_set[0] == 3'h0 |-> eff_loops[0] == LOOPS_DEF)
    else $error("zero loops not read as one");
  a_range_order: assert property (
    meas_lower[0] <= meas_upper[0] && meas_upper[0] <= disp_upper[0])
    else $error("range limits out of order");

  c_burnout_on: cover property (
    optype[0] == OP_BURNOUT && done[0] && phase[0]);
  c_burnout_off: cover property (
    optype[0] == OP_BURNOUT && done[0] && !phase[0]);
  c_abort: cover property (state[0] == CTSMP_MEAS && edge_seen[0]);
  c_alarm: cover property ($rose(input_failure_alarm[0]));
endmodule

//--- hdl/ctsmp_pkg.sv
package ctsmp_pkg;
  localparam int          NCH           = 2;
  localparam int          NOUT          = 5;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          CYC_PER_MS    = CLK_HZ / 1000;
  localparam int          MEAS_MS       = 100;
  localparam int          MEAS_CYC      = MEAS_MS * CYC_PER_MS;
  localparam logic [8:0]  WAIT_MIN_MS   = 9'h014;
  localparam logic [8:0]  WAIT_MAX_MS   = 9'h12C;
  localparam logic [8:0]  WAIT_DEF_MS   = 9'h01E;
  localparam int          TMR_W         = 23;
  localparam int          CUR_W         = 16;
  localparam int          RAW_W         = 17;
  localparam logic        OP_BURNOUT    = 1'b0;
  localparam logic        OP_MEASURE    = 1'b1;
  localparam logic [2:0]  SEL_DEF       = 3'h0;
  localparam logic [2:0]  SEL_MAX       = 3'h4;
  localparam logic [5:0]  TURNS_DEF     = 6'h08;
  localparam logic [5:0]  TURNS_MAX     = 6'h28;
  localparam logic [5:0]  TURNS_LEGACY  = 6'h08;
  localparam logic [2:0]  LOOPS_DEF     = 3'h1;
  localparam logic [2:0]  LOOPS_MAX     = 3'h6;
  localparam logic [2:0]  LOOPS_LEGACY  = 3'h1;
  localparam logic [15:0] FW_MIN_VER    = 16'h00CC;
  // range factors in 0.01 A per (turns/100 / loops)
  localparam logic [9:0]  DISP_HI_K     = 10'h36B;
  localparam logic [9:0]  MEAS_HI_K     = 10'h271;
  localparam logic [9:0]  MEAS_LO_K     = 10'h005;
  // secondary current in uA; primary 0.01 A = raw * turns / (100 * loops)
  localparam logic [6:0]  RAW_DIV       = 7'h64;
  localparam logic [RAW_W-1:0] RAW_SAT  = 17'h1FFFF;

  typedef enum logic [1:0] {
    CTSMP_IDLE = 2'b00,
    CTSMP_WAIT = 2'b01,
    CTSMP_MEAS = 2'b10
  } ctsmp_state_t;
endpackage

//--- hdl/ctsmp_range.sv
`timescale 1ns/1ps
module ctsmp_range
  import ctsmp_pkg::*;
(
  input  wire logic [5:0]       turns_set, // turns / 100, 0 means 8
  input  wire logic [2:0]       loops_set, // wire passes, 0 means 1
  input  wire logic             legacy,    // firmware before threshold
  input  wire logic [RAW_W-1:0] raw_peak,  // secondary current, uA
  output logic      [5:0]       eff_turns, // effective turns / 100
  output logic      [2:0]       eff_loops, // effective loops
  output logic      [CUR_W-1:0] disp_hi,   // display upper, 0.01 A
  output logic      [CUR_W-1:0] meas_lo,   // measure lower, 0.01 A
  output logic      [CUR_W-1:0] meas_hi,   // measure upper, 0.01 A
  output logic      [CUR_W-1:0] scaled     // primary current, 0.01 A
);
  function automatic logic [CUR_W-1:0] range_of(input logic [9:0] k,
                                                input logic [5:0] t,
                                                input logic [2:0] l);
    logic [15:0] prod;
    prod = 16'(k * t);
    return CUR_W'(prod / l);
  endfunction

  logic [22:0] raw_prod;
  logic [9:0]  raw_den;

  always_comb begin
    if (legacy) begin
      eff_turns = TURNS_LEGACY;
      eff_loops = LOOPS_LEGACY;
    end else begin
      eff_turns = (turns_set == 6'h00) ? TURNS_DEF :
                  (turns_set > TURNS_MAX) ? TURNS_MAX : turns_set;
      eff_loops = (loops_set == 3'h0) ? LOOPS_DEF :
                  (loops_set > LOOPS_MAX) ? LOOPS_MAX : loops_set;
    end
  end

  always_comb begin
    disp_hi  = range_of(DISP_HI_K, eff_turns, eff_loops);
    meas_hi  = range_of(MEAS_HI_K, eff_turns, eff_loops);
    meas_lo  = range_of(MEAS_LO_K, eff_turns, eff_loops);
    // integer math in 0.01 A keeps error well under 0.1 A
    raw_prod = 23'(raw_peak * eff_turns);
    raw_den  = 10'(RAW_DIV * eff_loops);
    scaled   = CUR_W'(raw_prod / raw_den);
  end
endmodule

//--- testbench/ctsmp_ct_model.sv
`timescale 1ns/1ps
module ctsmp_ct_model
  import ctsmp_pkg::*;
(
  input  wire logic                      clk_sys,    // clock
  input  wire logic                      rst_b,      // reset
  input  wire logic [NCH-1:0]            heater_on,  // load energised
  input  wire logic [NCH-1:0][RAW_W-1:0] on_ua,      // current, load on
  input  wire logic [NCH-1:0][RAW_W-1:0] off_ua,     // leakage, load off
  output logic      [NCH-1:0]            raw_valid,  // sample strobe
  output logic      [NCH-1:0][RAW_W-1:0] raw_current // sample, uA
);
  logic [1:0] phase;

  // one sample every fourth cycle; the bus is scrambled in between
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      raw_valid <= '0;
      raw_current <= '0;
    end else begin
      phase <= phase + 2'h1;
      for (int c = 0; c < NCH; c++) begin
        raw_valid[c] <= (phase == 2'h3);
        if (phase == 2'h3) begin
          raw_current[c] <= heater_on[c] ? on_ua[c] : off_ua[c];
        end else begin
          raw_current[c] <= ~raw_current[c];
        end
      end
    end
  end
endmodule

//--- testbench/ctsmp_top_tb.sv
`timescale 1ns/1ps
module ctsmp_top_tb
  import ctsmp_pkg::*;
;
  localparam int MC = 50;
  logic                      clk_sys = 1'b0;
  logic                      rst_b = 1'b0;
  logic [NOUT-1:0]           out_state = '0;
  logic [NCH-1:0]            raw_valid, on_update, input_failure_alarm;
  logic [NCH-1:0]            heater_on;
  logic [NCH-1:0][RAW_W-1:0] raw_current;
  logic [NCH-1:0][RAW_W-1:0] on_ua = '0;
  logic [NCH-1:0][RAW_W-1:0] off_ua = '0;
  logic                      chan1_operation_type = 1'b0;
  logic                      chan2_operation_type = 1'b0;
  logic [NCH-1:0][2:0]       monitor_sel = '0;
  logic [NCH-1:0][8:0]       wait_ms = {9'h01E, 9'h01E};
  logic [NCH-1:0][5:0]       turns_set = {6'h08, 6'h08};
  logic [NCH-1:0][2:0]       loops_set = {3'h1, 3'h1};
  logic [15:0]               firmware_version_item = 16'h00CC;
  logic [NCH-1:0][CUR_W-1:0] on_current, off_current;
  logic [NCH-1:0][CUR_W-1:0] disp_upper, meas_lower, meas_upper;
  int                        err_count = 0;
  int                        checks = 0;

  always #25 clk_sys = ~clk_sys;
  assign heater_on[0] = out_state[monitor_sel[0]];
  assign heater_on[1] = out_state[monitor_sel[1]];

  ctsmp_ct_model ct (.clk_sys(clk_sys), .rst_b(rst_b),
    .heater_on(heater_on), .on_ua(on_ua), .off_ua(off_ua),
    .raw_valid(raw_valid), .raw_current(raw_current));

  ctsmp_top #(.MEAS_CYCLES(MC), .CYC_MS(2)) uut (.clk_sys(clk_sys),
    .rst_b(rst_b), .out_state(out_state), .raw_valid(raw_valid),
    .raw_current(raw_current), .chan1_operation_type(chan1_operation_type),
    .chan2_operation_type(chan2_operation_type),
    .monitor_sel(monitor_sel), .wait_ms(wait_ms), .turns_set(turns_set),
    .loops_set(loops_set), .firmware_version_item(firmware_version_item),
    .on_current(on_current), .off_current(off_current),
    .on_update(on_update), .input_failure_alarm(input_failure_alarm),
    .disp_upper(disp_upper), .meas_lower(meas_lower),
    .meas_upper(meas_upper));

  task automatic test_done();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // counts falling edges until the channel's update pulse shows
  task automatic wait_upd(input int ch, bnd, input bit must, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (on_update[ch] !== 1'b1 && n < bnd);
    if (must && on_update[ch] !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t no update", $time);
      test_done();
    end
  endtask

  task automatic t_burnout();
    logic [2:0] sv [3] = '{3'h0, 3'h1, 3'h4};
    logic [8:0] wv [3] = '{9'h01E, 9'h1F4, 9'h005};
    int         wc [3] = '{60, 600, 40};
    int         n;
    for (int i = 0; i < 3; i++) begin
      monitor_sel[0] = sv[i];
      wait_ms[0] = wv[i];
      on_ua[0] = 17'(5000 + i * 100);
      off_ua[0] = 17'd1000;
      out_state[sv[i]] = 1'b1;
      wait_upd(0, 800, 1'b1, n);
      chk(on_current[0], 16'(400 + 8 * i), "on value");
      chk(16'(n >= wc[i] + MC && n <= wc[i] + MC + 4), 16'h1, "wait");
      out_state[sv[i]] = 1'b0;
      wait_upd(0, wc[i] + MC + 8, 1'b0, n);
      chk(16'(n), 16'(wc[i] + MC + 8), "pulse on off");
      chk(off_current[0], 16'd80, "off value");
    end
    out_state[3] = 1'b1;
    wait_upd(0, 150, 1'b0, n);
    chk(16'(n), 16'd150, "unwatched output");
    out_state[3] = 1'b0;
  endtask

  task automatic t_abort();
    int n;
    wait_ms[0] = 9'h01E;
    monitor_sel[0] = 3'h0;
    on_ua[0] = 17'd7500;
    out_state[0] = 1'b1;
    repeat (80) @(negedge clk_sys);
    out_state[0] = 1'b0;
    repeat (10) @(negedge clk_sys);
    out_state[0] = 1'b1;
    wait_upd(0, 300, 1'b1, n);
    chk(16'(n >= 60 + MC && n <= 64 + MC), 16'h1, "restart");
    chk(on_current[0], 16'd600, "after abort");
    out_state[0] = 1'b0;
  endtask

  task automatic t_measure();
    int n;
    chan2_operation_type = 1'b1;
    monitor_sel[1] = 3'h0;
    on_ua[1] = 17'd9000;
    off_ua[1] = 17'd2000;
    wait_upd(1, 200, 1'b1, n);
    wait_upd(1, 200, 1'b1, n);
    chk(on_current[1], 16'd160, "meas value");
    chk(off_current[1], 16'h0, "meas off");
    chk(16'(n >= MC - 1 && n <= MC + 2), 16'h1, "period");
    chk(on_current[0], 16'd600, "other chan");
    chan1_operation_type = 1'b1;
    wait_upd(0, 200, 1'b1, n);
    wait_upd(0, 200, 1'b1, n);
    chk(on_current[0], 16'd80, "meas chan1");
    chk(off_current[0], 16'h0, "meas off chan1");
    chan1_operation_type = 1'b0;
  endtask

  task automatic t_alarm();
    logic [16:0] rv [4] = '{17'd87500, 17'd90000, 17'h1FFFF, 17'd90000};
    logic [15:0] fv [4] = '{16'h00CC, 16'h00CC, 16'h00CC, 16'h00CB};
    logic [5:0]  tv [4] = '{6'h08, 6'h08, 6'h08, 6'h28};
    logic        av [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    int          n;
    for (int i = 0; i < 4; i++) begin
      off_ua[1] = rv[i];
      firmware_version_item = fv[i];
      turns_set[1] = tv[i];
      wait_upd(1, 200, 1'b1, n);
      wait_upd(1, 200, 1'b1, n);
      chk({15'h0, input_failure_alarm[1]}, {15'h0, av[i]}, "alarm");
      chk(disp_upper[1], 16'd7000, "range");
      if (i != 2) begin
        chk(on_current[1], 16'(rv[i] * 8 / 100), "scaled");
      end
    end
    firmware_version_item = 16'h00CC;
  endtask

  task automatic t_ranges();
    logic [5:0]  tv [5] = '{6'h00, 6'h01, 6'h08, 6'h28, 6'h08};
    logic [2:0]  lv [5] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h2};
    logic [15:0] k [5] = '{16'd8, 16'd1, 16'd8, 16'd40, 16'd4};
    for (int i = 0; i < 5; i++) begin
      turns_set[1] = tv[i];
      loops_set[1] = lv[i];
      repeat (2) @(negedge clk_sys);
      chk(disp_upper[1], k[i] * 16'd875, "disp hi");
      chk(meas_upper[1], k[i] * 16'd625, "meas hi");
      chk(meas_lower[1], k[i] * 16'd5, "meas lo");
    end
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_burnout();
    t_abort();
    t_measure();
    t_alarm();
    t_ranges();
    test_done();
  end
endmodule
